// >>> adc_front_model.sv
// Behavioural comparator, ladder tap and trigger source facing the sequencer.
// Assumes inputs are scaled in 1/2048 of reference and the bench sets trig_level.
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  input  wire logic       sys_clk,
  input  wire logic [9:0] tap_code,
  input  wire logic [3:0] channel_sel,
  input  wire logic       sample_hold,
  input  wire logic       trig_level,
  output logic            comparator_high,
  output logic            external_trigger_pin
);
  // ----------------------------------------------------------------
  // Sample and hold, comparator
  // ----------------------------------------------------------------
  int held = 0;
  // Held value follows the chosen input only while sampling
  always @(posedge sys_clk)
    if (sample_hold === 1'b1)
      held <= int'(channel_sel) * 170 + 37;
  // Tap sits half a step low, which gives the rounding by one half
  assign comparator_high = (held >= 2 * int'(tap_code) - 1);
  assign external_trigger_pin = trig_level;
endmodule
`default_nettype wire

// >>> sar_adc_pkg.sv
// Shared constants and types of the successive-approximation converter sequencer.
// Assumes one synchronous system clock; registers sit at fixed word addresses.
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_MAIN_ADDR = 32'hFFFFF3C0;
  localparam logic [31:0] CHAN_SEL_ADDR  = 32'hFFFFF3C2;
  localparam logic [31:0] RESULT_ADDR    = 32'hFFFFF3C4;
  localparam logic [31:0] SUPPLY_ADDR    = 32'hFFFFF3C8;

  localparam logic [7:0]  MODE_MAIN_RST  = 8'h00;
  localparam logic [3:0]  CHAN_SEL_RST   = 4'h0;
  localparam logic        SUPPLY_RST     = 1'h0;
  localparam logic [9:0]  RESULT_RST     = 10'h000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CONV_EN_BIT   = 7;
  localparam int HW_START_BIT  = 6;
  localparam int TIME_SEL_HI   = 5;
  localparam int TIME_SEL_LO   = 3;
  localparam int EDGE_SEL_HI   = 2;
  localparam int EDGE_SEL_LO   = 1;
  localparam int PWR_DOWN_BIT  = 0;
  localparam int REF_CONN_BIT  = 0;
  localparam int RESULT_SHIFT  = 6;

  localparam logic [9:0] SAR_MSB_MASK = 10'h200;
  localparam logic [3:0] SAR_MSB_IDX  = 4'h9;

  // ----------------------------------------------------------------
  // Trigger edge selection
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Timing, in system clock cycles, indexed by the time select field
  // ----------------------------------------------------------------
  localparam int CONV_CYC [8] = '{168, 120, 84, 60, 48, 36, 0, 12};
  localparam int STAB_CYC [8] = '{64, 60, 42, 30, 24, 18, 0, 6};
  localparam int STEPS_PER_CONV = 12;
  localparam int SAMPLE_STEPS   = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_TRIG, ST_STAB, ST_SAMPLE, ST_TRIAL} conv_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    conv_state_t state;
    logic [7:0]  mode;
    logic [3:0]  chan;
    logic        supply;
    logic [9:0]  result;
    logic [9:0]  sar;
    logic [3:0]  bit_idx;
    logic        hold;
    logic        irq;
    logic [15:0] rdata;
  } seq_t;

  typedef struct packed {
    logic [7:0] cnt;
  } timer_t;

  typedef struct packed {
    logic prev;
    logic armed;
  } edge_t;

endpackage

// >>> sar_adc_sequencer.sv
// Sequencer of a 10-bit successive-approximation converter with 12 inputs.
// Assumes an analog comparator and ladder outside; all inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire sar_adc_pkg::reg_req_t reg_req,
  output logic [15:0]                reg_rd_data,
  input  wire logic                  comparator_high,
  input  wire logic                  external_trigger_pin,
  output logic [9:0]                 tap_code,
  output logic [3:0]                 channel_sel,
  output logic                       sample_hold,
  output logic                       ref_supply_connect,
  output logic                       comparator_power_down,
  output logic                       conversion_done_irq
);

  sar_adc_pkg::seq_t s;
  sar_adc_pkg::seq_t n;

  logic       wr_mode;
  logic       wr_chan;
  logic       wr_supply;
  logic       busy;
  logic       abort;
  logic       new_en;
  logic       new_hw;
  logic       restart;
  logic       tload;
  logic [7:0] tval;
  logic [7:0] step_cyc;
  logic [7:0] stab_cyc;
  logic [9:0] decided;
  logic       expired;
  logic       trig_edge;
  logic [2:0] time_sel;

  // ----------------------------------------------------------------
  // Phase timer and trigger edge
  // ----------------------------------------------------------------
  step_timer u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (tload),
    .load_val (tval),
    .expired  (expired)
  );

  trig_edge_detect u_edge (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin        (external_trigger_pin),
    .edge_sel   (s.mode[sar_adc_pkg::EDGE_SEL_HI:sar_adc_pkg::EDGE_SEL_LO]),
    .edge_pulse (trig_edge)
  );

  // ----------------------------------------------------------------
  // Register access and sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    n = s;
    n.irq = 1'b0;
    restart = 1'b0;
    decided = s.sar;
    time_sel = s.mode[sar_adc_pkg::TIME_SEL_HI:sar_adc_pkg::TIME_SEL_LO];
    // Prohibited time code has a zero table entry; one cycle keeps the sequence alive
    step_cyc = 8'(sar_adc_pkg::CONV_CYC[time_sel] / sar_adc_pkg::STEPS_PER_CONV);
    if (step_cyc == 8'h00)
      step_cyc = 8'h01;
    stab_cyc = 8'(sar_adc_pkg::STAB_CYC[time_sel]);
    if (stab_cyc == 8'h00)
      stab_cyc = 8'h01;

    wr_mode   = reg_req.wr && (reg_req.addr == sar_adc_pkg::MODE_MAIN_ADDR);
    wr_chan   = reg_req.wr && (reg_req.addr == sar_adc_pkg::CHAN_SEL_ADDR);
    wr_supply = reg_req.wr && (reg_req.addr == sar_adc_pkg::SUPPLY_ADDR);
    busy = (s.state == sar_adc_pkg::ST_STAB) || (s.state == sar_adc_pkg::ST_SAMPLE)
        || (s.state == sar_adc_pkg::ST_TRIAL);

    if (wr_supply)
      n.supply = reg_req.data[sar_adc_pkg::REF_CONN_BIT];
    if (wr_chan)
      n.chan = reg_req.data[3:0];
    if (wr_mode)
      n.mode = reg_req.data[7:0];

    if (reg_req.rd)
    begin
      case (reg_req.addr)
        sar_adc_pkg::MODE_MAIN_ADDR: n.rdata = {8'h00, s.mode};
        sar_adc_pkg::CHAN_SEL_ADDR:  n.rdata = {12'h000, s.chan};
        sar_adc_pkg::SUPPLY_ADDR:    n.rdata = {15'h0000, s.supply};
        sar_adc_pkg::RESULT_ADDR:    n.rdata = {s.result, 6'h00};
        default:                     n.rdata = 16'h0000;
      endcase
    end

    // Normal sequence, driven by the stored mode
    case (s.state)
      sar_adc_pkg::ST_IDLE:
      begin
        if (s.mode[sar_adc_pkg::CONV_EN_BIT])
        begin
          if (s.mode[sar_adc_pkg::HW_START_BIT])
            n.state = sar_adc_pkg::ST_WAIT_TRIG;
          else
            restart = 1'b1;
        end
      end
      sar_adc_pkg::ST_WAIT_TRIG:
      begin
        if (!s.mode[sar_adc_pkg::CONV_EN_BIT])
          n.state = sar_adc_pkg::ST_IDLE;
        else if (!s.mode[sar_adc_pkg::HW_START_BIT] || trig_edge)
          restart = 1'b1;
      end
      sar_adc_pkg::ST_STAB:
      begin
        if (expired)
          n.state = sar_adc_pkg::ST_SAMPLE;
      end
      sar_adc_pkg::ST_SAMPLE:
      begin
        if (expired)
        begin
          n.state   = sar_adc_pkg::ST_TRIAL;
          n.sar     = sar_adc_pkg::SAR_MSB_MASK;
          n.bit_idx = sar_adc_pkg::SAR_MSB_IDX;
        end
      end
      sar_adc_pkg::ST_TRIAL:
      begin
        if (expired)
        begin
          // Comparator decides the bit under trial; ladder offset gives the half-step rounding
          if (!comparator_high)
            decided[s.bit_idx] = 1'b0;
          n.sar = decided;
          if (s.bit_idx == 4'h0)
          begin
            n.result = decided;
            n.irq = 1'b1;
            if (s.mode[sar_adc_pkg::HW_START_BIT])
              n.state = sar_adc_pkg::ST_WAIT_TRIG;
            else
              restart = 1'b1;
          end
          else
          begin
            n.bit_idx = s.bit_idx - 4'h1;
            n.sar = decided | 10'(10'h001 << (s.bit_idx - 4'h1));
          end
        end
      end
      default:
      begin
        n.state = sar_adc_pkg::ST_IDLE;
      end
    endcase

    // A mode or channel write during a conversion overrides the state, result and done pulse decided above
    new_en = wr_mode ? reg_req.data[sar_adc_pkg::CONV_EN_BIT] : s.mode[sar_adc_pkg::CONV_EN_BIT];
    new_hw = wr_mode ? reg_req.data[sar_adc_pkg::HW_START_BIT] : s.mode[sar_adc_pkg::HW_START_BIT];
    abort = busy && (wr_mode || wr_chan);
    if (abort)
    begin
      n.result = s.result;
      n.irq = 1'b0;
      restart = 1'b0;
      if (!new_en)
        n.state = sar_adc_pkg::ST_IDLE;
      else if (new_hw)
        n.state = sar_adc_pkg::ST_WAIT_TRIG;
      else
        restart = 1'b1;
    end

    if (restart)
    begin
      n.sar = 10'h000;
      n.bit_idx = sar_adc_pkg::SAR_MSB_IDX;
      // Stabilization only applies while the comparator is powered down between runs
      if (new_en && (wr_mode ? reg_req.data[sar_adc_pkg::PWR_DOWN_BIT]
                             : s.mode[sar_adc_pkg::PWR_DOWN_BIT]))
        n.state = sar_adc_pkg::ST_STAB;
      else
        n.state = sar_adc_pkg::ST_SAMPLE;
    end
    if ((n.state == sar_adc_pkg::ST_IDLE) || (n.state == sar_adc_pkg::ST_WAIT_TRIG))
      n.sar = 10'h000;
    n.hold = (n.state == sar_adc_pkg::ST_SAMPLE);

    // Each phase reloads the pacing counter on entry or on the next trial bit
    tload = restart || (n.state != s.state) || (n.bit_idx != s.bit_idx);
    case (n.state)
      sar_adc_pkg::ST_STAB:   tval = stab_cyc;
      sar_adc_pkg::ST_SAMPLE: tval = 8'(step_cyc * sar_adc_pkg::SAMPLE_STEPS);
      default:                tval = step_cyc;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s        <= '0;
      s.state  <= sar_adc_pkg::ST_IDLE;
      s.mode   <= sar_adc_pkg::MODE_MAIN_RST;
      s.chan   <= sar_adc_pkg::CHAN_SEL_RST;
      s.supply <= sar_adc_pkg::SUPPLY_RST;
      s.result <= sar_adc_pkg::RESULT_RST;
    end
    else
    begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rd_data           = s.rdata;
  assign tap_code              = s.sar;
  assign channel_sel           = s.chan;
  assign sample_hold           = s.hold;
  assign ref_supply_connect    = s.supply;
  assign comparator_power_down = s.mode[sar_adc_pkg::PWR_DOWN_BIT];
  assign conversion_done_irq   = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_chan_reset_zero: assert property (disable iff (1'b0) rst |=> channel_sel == 4'h0)
    else $error("channel select not cleared by reset");
  a_result_reset_zero: assert property (disable iff (1'b0) rst |=> s.result == 10'h000)
    else $error("result not cleared by reset");
  a_supply_reset_open: assert property (disable iff (1'b0) rst |=> !ref_supply_connect)
    else $error("supply switch not open after reset");
  a_chan_follows_write: assert property ($changed(channel_sel) |-> $past(wr_chan))
    else $error("channel changed without a write");
  a_supply_bit_write: assert property (
    wr_supply |=> ref_supply_connect == $past(reg_req.data[0]))
    else $error("supply switch does not follow bit 0");
  a_first_trial_msb: assert property (
    s.state == sar_adc_pkg::ST_SAMPLE && expired && !abort
    |=> tap_code == 10'h200 && s.state == sar_adc_pkg::ST_TRIAL)
    else $error("first trial is not the half tap");
  a_second_tap_pick: assert property (
    s.state == sar_adc_pkg::ST_TRIAL && s.bit_idx == 4'h9 && expired && !abort
    |=> tap_code[9] == $past(comparator_high) && tap_code[8])
    else $error("second tap not chosen from first bit");
  // Tap is cleared once the result is latched, so the result is rebuilt from the last trial
  a_done_after_lsb: assert property (
    conversion_done_irq |-> $past(s.state) == sar_adc_pkg::ST_TRIAL && $past(s.bit_idx) == 4'h0
    && s.result == {$past(tap_code[9:1]), $past(comparator_high)})
    else $error("done pulse without last trial");
  a_result_low_zero: assert property (
    reg_req.rd && reg_req.addr == sar_adc_pkg::RESULT_ADDR
    |=> reg_rd_data[5:0] == 6'h00 && reg_rd_data[15:6] == $past(s.result))
    else $error("result read layout wrong");
  a_sw_back_to_back: assert property (
    conversion_done_irq && !s.mode[6] && s.mode[7]
    |-> s.state inside {sar_adc_pkg::ST_STAB, sar_adc_pkg::ST_SAMPLE})
    else $error("software start did not restart");
  a_hw_one_shot: assert property (
    conversion_done_irq && s.mode[6] |-> s.state == sar_adc_pkg::ST_WAIT_TRIG)
    else $error("hardware start did not wait for edge");
  a_stop_no_store: assert property (
    busy && wr_mode && !reg_req.data[7]
    |=> s.state == sar_adc_pkg::ST_IDLE && !conversion_done_irq && $stable(s.result))
    else $error("stop did not halt without storing");
  a_hw_abort_wait: assert property (
    busy && wr_mode && reg_req.data[7] && reg_req.data[6]
    |=> s.state == sar_adc_pkg::ST_WAIT_TRIG)
    else $error("hardware abort did not wait");
  a_trial_paced: assert property (
    s.state == sar_adc_pkg::ST_TRIAL && tload && n.state == sar_adc_pkg::ST_TRIAL
    && tval > 8'h01 |=> !expired)
    else $error("trial ended without pacing");

  c_sw_done:   cover property (conversion_done_irq && !s.mode[6]);
  c_hw_done:   cover property (conversion_done_irq && s.mode[6]);
  c_abort_sw:  cover property (abort && new_en && !new_hw);
  c_stop:      cover property (abort && !new_en);

endmodule
`default_nettype wire

// >>> step_timer.sv
// Down counter that paces one phase of a conversion.
// Assumes load is a one-cycle request; expired marks the last cycle of the phase.
`timescale 1ns/1ps
`default_nettype none
module step_timer (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  output logic            expired
);

  sar_adc_pkg::timer_t s;
  sar_adc_pkg::timer_t n;

  always_comb
  begin
    n = s;
    if (load)
    begin
      n.cnt = load_val;
    end
    else if (s.cnt != 8'h00)
    begin
      n.cnt = s.cnt - 8'h01;
    end
    // Not gated by load: the sequencer's reload decision depends on this flag
    expired = (s.cnt == 8'h01);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= n;
  end

endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the converter sequencer with a behavioural front end.
// Assumes the design package is compiled first; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic                  sys_clk    = 1'b0;
  logic                  rst        = 1'b1;
  sar_adc_pkg::reg_req_t reg_req    = '0;
  logic                  trig_level = 1'b0;
  logic [15:0]           reg_rd_data;
  logic [15:0]           rd_val;
  logic [9:0]            tap_code;
  logic [3:0]            channel_sel;
  logic                  comparator_high;
  logic                  external_trigger_pin;
  logic                  sample_hold;
  logic                  ref_supply_connect;
  logic                  comparator_power_down;
  logic                  conversion_done_irq;
  int                    n_mismatch  = 0;
  int                    comparisons = 0;
  int                    irq_cnt     = 0;
  int                    cycles      = 0;

  always #20 sys_clk = ~sys_clk;

  sar_adc_sequencer sar_adc_sequencer_i (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .comparator_high(comparator_high), .external_trigger_pin(external_trigger_pin),
    .tap_code(tap_code), .channel_sel(channel_sel), .sample_hold(sample_hold),
    .ref_supply_connect(ref_supply_connect),
    .comparator_power_down(comparator_power_down),
    .conversion_done_irq(conversion_done_irq)
  );

  adc_front_model adc_front_model_i (
    .sys_clk(sys_clk), .tap_code(tap_code), .channel_sel(channel_sel),
    .sample_hold(sample_hold), .trig_level(trig_level),
    .comparator_high(comparator_high), .external_trigger_pin(external_trigger_pin)
  );

  always @(posedge sys_clk)
  begin
    cycles++;
    if (conversion_done_irq === 1'b1)
      irq_cnt++;
    // Whole plan needs well under a thousand cycles; this only cuts a hang
    if (cycles == 8000)
    begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_req = '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
    @(negedge sys_clk);
    reg_req = '0;
  endtask

  task automatic reg_rd(input logic [31:0] a);
    @(negedge sys_clk);
    reg_req = '{addr: a, data: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(negedge sys_clk);
    reg_req = '0;
    @(negedge sys_clk);
    rd_val = reg_rd_data;
  endtask

  task automatic rd_check(input string name, input logic [31:0] a, input logic [15:0] exp);
    reg_rd(a);
    check(name, exp, rd_val);
  endtask

  task automatic wait_irq();
    int n0;
    n0 = irq_cnt;
    repeat (400)
    begin
      @(negedge sys_clk);
      if (irq_cnt != n0)
        break;
    end
    check("irq seen", 16'h0001, 16'(irq_cnt != n0));
  endtask

  task automatic irq_over(input int len, input int exp);
    int n0;
    n0 = irq_cnt;
    repeat (len) @(negedge sys_clk);
    check("irq count", 16'(exp), 16'(irq_cnt - n0));
  endtask

  // Expected result word of a channel: code in the upper ten bits
  function automatic logic [15:0] word_of(input int ch);
    return 16'(((ch * 170 + 37 + 1) / 2) << 6);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_check("chan", sar_adc_pkg::CHAN_SEL_ADDR, 16'h0000);
    rd_check("supply", sar_adc_pkg::SUPPLY_ADDR, 16'h0000);
    rd_check("result", sar_adc_pkg::RESULT_ADDR, 16'h0000);
    check("ref out", 16'h0000, 16'(ref_supply_connect));
  endtask

  task automatic t_regs();
    reg_wr(sar_adc_pkg::SUPPLY_ADDR, 16'hFFFF);
    rd_check("supply", sar_adc_pkg::SUPPLY_ADDR, 16'h0001);
    check("ref out", 16'h0001, 16'(ref_supply_connect));
    reg_wr(sar_adc_pkg::RESULT_ADDR, 16'hFFC0);
    rd_check("result ro", sar_adc_pkg::RESULT_ADDR, 16'h0000);
    rd_check("unmapped", 32'hFFFFF3D0, 16'h0000);
    reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'h0001);
    check("pd out", 16'h0001, 16'(comparator_power_down));
    // Upper channel bits kept zero by software
    reg_wr(sar_adc_pkg::CHAN_SEL_ADDR, 16'h000B);
    rd_check("chan", sar_adc_pkg::CHAN_SEL_ADDR, 16'h000B);
    check("chan out", 16'h000B, 16'(channel_sel));
  endtask

  task automatic t_sw();
    int k;
    reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'h00B8);
    k = 0;
    while (sample_hold !== 1'b1 && k < 50)
    begin
      @(negedge sys_clk);
      k++;
    end
    while (sample_hold === 1'b1 && k < 100)
    begin
      @(negedge sys_clk);
      k++;
    end
    check("tap first", 16'h0200, 16'(tap_code));
    @(negedge sys_clk);
    check("tap second", 16'h0300, 16'(tap_code));
    wait_irq();
    rd_check("result ch11", sar_adc_pkg::RESULT_ADDR, word_of(11));
    wait_irq();
    reg_wr(sar_adc_pkg::CHAN_SEL_ADDR, 16'h0003);
    wait_irq();
    rd_check("result ch3", sar_adc_pkg::RESULT_ADDR, word_of(3));
    repeat (4) @(negedge sys_clk);
    reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'h0038);
    irq_over(40, 0);
    rd_check("result kept", sar_adc_pkg::RESULT_ADDR, word_of(3));
  endtask

  task automatic t_hw_edges();
    // Edges stand apart by more than a conversion; an edge during one would be ignored
    int exp_rise [4] = '{0, 0, 1, 1};
    int exp_fall [4] = '{0, 1, 0, 1};
    for (int e = 0; e < 4; e++)
    begin
      reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'(8'hF8 | (e << 1)));
      irq_over(30, 0);
      trig_level = 1'b1;
      irq_over(30, exp_rise[e]);
      trig_level = 1'b0;
      irq_over(30, exp_fall[e]);
    end
  endtask

  task automatic t_hw_abort();
    reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'h00FC);
    trig_level = 1'b1;
    repeat (4) @(negedge sys_clk);
    reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'h00FC);
    trig_level = 1'b0;
    irq_over(40, 0);
    trig_level = 1'b1;
    irq_over(40, 1);
    trig_level = 1'b0;
  endtask

  task automatic t_timing();
    int k;
    int w;
    int step;
    step = sar_adc_pkg::CONV_CYC[0] / sar_adc_pkg::STEPS_PER_CONV;
    reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'h0080);
    k = 0;
    w = 0;
    while (sample_hold !== 1'b1 && k < 100)
    begin
      @(negedge sys_clk);
      k++;
    end
    while (sample_hold === 1'b1 && w < 100)
    begin
      @(negedge sys_clk);
      w++;
    end
    // Slowest setting: 168 cycles split over 12 steps, two of them sampling
    check("sample width", 16'(step * sar_adc_pkg::SAMPLE_STEPS), 16'(w));
    w = 0;
    while (tap_code === 10'h200 && w < 100)
    begin
      @(negedge sys_clk);
      w++;
    end
    check("trial width", 16'(step), 16'(w));
    reg_wr(sar_adc_pkg::MODE_MAIN_ADDR, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_sw();
    t_hw_edges();
    t_hw_abort();
    t_timing();
    results();
  end
endmodule
`default_nettype wire

// >>> trig_edge_detect.sv
// Edge detector for the external trigger pin.
// Assumes the pin is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module trig_edge_detect (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            edge_pulse
);

  sar_adc_pkg::edge_t s;
  sar_adc_pkg::edge_t n;
  logic rise;
  logic fall;

  // No edge is reported before a first sample exists, so a pin high at reset is not a rise
  always_comb
  begin
    n.prev  = pin;
    n.armed = 1'b1;
    rise = s.armed && pin && !s.prev;
    fall = s.armed && !pin && s.prev;
    case (edge_sel)
      sar_adc_pkg::EDGE_FALL: edge_pulse = fall;
      sar_adc_pkg::EDGE_RISE: edge_pulse = rise;
      sar_adc_pkg::EDGE_BOTH: edge_pulse = rise || fall;
      default:                edge_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= n;
  end

endmodule
`default_nettype wire
